//--- bench/tb_bridge_device_control_diag_regs.sv
// Self-checking bench for the control and diagnostic register group
`timescale 1ns/1ps
`include "bdcdr_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module tb_bridge_device_control_diag_regs;
	import bdcdr_pkg::*;

	logic            pclk, presetn, global_reset_n, ce, psel, penable, pwrite;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata;
	logic [3:0]      pstrb, legacy_805_hi;
	logic            pready, pslverr, power_state_d3, power_on_req, power_off_req;
	logic            socket_power_on, socket_3v_capable, serial_irq_en, parallel_int_en;
	bdcdr_int_mode_t interrupt_signal_mode;
	logic [15:0]     vendor_id_in, device_id_in, vendor_id_out, device_id_out;
	logic            status_change_event, legacy_803_bit4, status_change_irq, delayed_txn_enable;
	logic [6:0]      target_latency_limit;
	logic [1:0]      discard_pending, discard_expired;
	int              n_errors = 0;
	int              num_checks = 0;

	bdcdr_regs #(.DISCARD_SHORT(8), .DISCARD_LONG(64)) dut (.pclk, .presetn, .global_reset_n,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
		.power_state_d3, .power_on_req, .power_off_req, .socket_power_on, .socket_3v_capable,
		.interrupt_signal_mode, .serial_irq_en, .parallel_int_en, .vendor_id_in, .device_id_in,
		.vendor_id_out, .device_id_out, .status_change_event, .legacy_803_bit4, .legacy_805_hi,
		.status_change_irq, .delayed_txn_enable, .target_latency_limit, .discard_pending,
		.discard_expired);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ------------------------------------------------------------------------
	// Bus, stimulus, check and reporting tasks
	// ------------------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		`CHK(nm, {24'h00_0000, x}, r)
		`CHK(nm, xe, e)
	endtask : rdc

	task automatic settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task automatic sci(input logic b803, input logic [3:0] h805, input logic x);
		@(posedge pclk);
		legacy_803_bit4 <= b803;
		legacy_805_hi   <= h805;
		settle();
		`CHK("status irq", x, status_change_irq)
	endtask : sci

	task automatic disc(input logic [7:0] dg, input int gap);
		int th, tc;
		th = 0;
		tc = 0;
		wr(`BDCDR_ADDR_DIAG_CTRL, dg);
		@(posedge pclk);
		discard_pending <= 2'b11;
		for (int k = 1; k <= 100; k++) begin
			@(posedge pclk);
			#1;
			if (th == 0 && discard_expired[0] === 1'b1) th = k;
			if (tc == 0 && discard_expired[1] === 1'b1) tc = k;
		end
		@(posedge pclk);
		discard_pending <= 2'b00;
		`CHK("discard gap", gap, tc - th)
		`CHK("short expiry", 1'b1, (th inside {8, 9}) || (tc inside {8, 9}))
	endtask : disc

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		{presetn, global_reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{power_state_d3, power_on_req, power_off_req, status_change_event} = '0;
		{legacy_803_bit4, legacy_805_hi, discard_pending} = '0;
		ce = 1'b1;
		pstrb = 4'h1;
		vendor_id_in = 16'h1234;
		device_id_in = 16'h5678;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		global_reset_n <= 1'b1;
		rdc("control", `BDCDR_ADDR_DEV_CTRL, 8'h66, 1'b0);
		rdc("diag", `BDCDR_ADDR_DIAG_CTRL, 8'h60, 1'b0);
		rdc("cap id", `BDCDR_ADDR_CAP_ID, 8'h01, 1'b0);
		rdc("next ptr", `BDCDR_ADDR_NEXT_PTR, 8'h00, 1'b0);
		`CHK("vendor id", 16'h1234, vendor_id_out)
		`CHK("latency", 7'd16, target_latency_limit)
		`CHK("delayed txn", 1'b1, delayed_txn_enable)
		wr(`BDCDR_ADDR_DEV_CTRL, 8'hf6);
		rdc("control", `BDCDR_ADDR_DEV_CTRL, 8'he6, 1'b0);
		pstrb <= 4'h0;
		wr(`BDCDR_ADDR_DEV_CTRL, 8'h00);
		pstrb <= 4'h1;
		rdc("control", `BDCDR_ADDR_DEV_CTRL, 8'he6, 1'b0);
		wr(`BDCDR_ADDR_CAP_ID, 8'hff);
		rdc("cap id", `BDCDR_ADDR_CAP_ID, 8'h01, 1'b0);
		wr(`BDCDR_ADDR_NEXT_PTR, 8'hff);
		rdc("next ptr", `BDCDR_ADDR_NEXT_PTR, 8'h00, 1'b0);
		rdc("unmapped", 12'h300, 8'h00, 1'b1);
		for (int m = 0; m < 4; m++) begin
			wr(`BDCDR_ADDR_DEV_CTRL, 8'h40 | 8'(m << 1));
			settle();
			`CHK("mode", 2'(m), interrupt_signal_mode)
			`CHK("serial", m >= 2, serial_irq_en)
			`CHK("parallel", m != 3, parallel_int_en)
			`CHK("3v", 1'b1, socket_3v_capable)
		end
		wr(`BDCDR_ADDR_DEV_CTRL, 8'h80);
		@(posedge pclk);
		power_state_d3 <= 1'b1;
		power_on_req <= 1'b1;
		@(posedge pclk);
		power_on_req <= 1'b0;
		power_off_req <= 1'b1;
		@(posedge pclk);
		power_off_req <= 1'b0;
		settle();
		`CHK("3v", 1'b0, socket_3v_capable)
		`CHK("power held", 1'b1, socket_power_on)
		wr(`BDCDR_ADDR_DEV_CTRL, 8'h00);
		@(posedge pclk);
		power_off_req <= 1'b1;
		@(posedge pclk);
		power_off_req <= 1'b0;
		settle();
		`CHK("power off", 1'b0, socket_power_on)
		wr(`BDCDR_ADDR_DIAG_CTRL, 8'h80);
		settle();
		`CHK("device id", 16'hffff, device_id_out)
		`CHK("vendor id", 16'hffff, vendor_id_out)
		wr(`BDCDR_ADDR_DIAG_CTRL, 8'h18);
		rdc("diag", `BDCDR_ADDR_DIAG_CTRL, 8'h58, 1'b0);
		`CHK("device id", 16'h5678, device_id_out)
		`CHK("delayed txn", 1'b0, delayed_txn_enable)
		`CHK("latency", 7'd64, target_latency_limit)
		wr(`BDCDR_ADDR_DIAG_CTRL, 8'h20);
		@(posedge pclk);
		status_change_event <= 1'b1;
		sci(1'b0, 4'h0, 1'b1);
		sci(1'b1, 4'h1, 1'b0);
		wr(`BDCDR_ADDR_DIAG_CTRL, 8'h00);
		sci(1'b1, 4'h1, 1'b1);
		sci(1'b0, 4'h0, 1'b0);
		disc(8'h02, 56);
		disc(8'h04, -56);
		wr(`BDCDR_ADDR_DEV_CTRL, 8'h20);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc("control", `BDCDR_ADDR_DEV_CTRL, 8'h20, 1'b0);
		@(posedge pclk);
		global_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		global_reset_n <= 1'b1;
		rdc("control", `BDCDR_ADDR_DEV_CTRL, 8'h66, 1'b0);
		rdc("diag", `BDCDR_ADDR_DIAG_CTRL, 8'h60, 1'b0);
		end_of_test();
	end

endmodule : tb_bridge_device_control_diag_regs

//--- hw/bdcdr_params.svh
// Offsets, field positions, reset values and timing counts of the register group
`ifndef BDCDR_PARAMS_SVH
`define BDCDR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define BDCDR_IDX_DEV_CTRL     8'h92
`define BDCDR_IDX_DIAG_CTRL    8'h93
`define BDCDR_IDX_CAP_ID       8'ha0
`define BDCDR_IDX_NEXT_PTR     8'ha1
`define BDCDR_ADDR_DEV_CTRL    12'h248
`define BDCDR_ADDR_DIAG_CTRL   12'h24c
`define BDCDR_ADDR_CAP_ID      12'h280
`define BDCDR_ADDR_NEXT_PTR    12'h284

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define BDCDR_RST_DEV_CTRL     8'h66
`define BDCDR_RST_DIAG_CTRL    8'h60
`define BDCDR_VAL_CAP_ID       8'h01
`define BDCDR_VAL_NEXT_PTR     8'h00
`define BDCDR_WMASK_DEV_CTRL   8'hef
`define BDCDR_WMASK_DIAG_CTRL  8'hbf
`define BDCDR_FORCE_DIAG_CTRL  8'h40
`define BDCDR_ID_MASKED        16'hffff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BDCDR_DC_POWER_HOLD    7
`define BDCDR_DC_THREE_VOLT    6
`define BDCDR_DC_AUX_IO        5
`define BDCDR_DC_RSVD4         4
`define BDCDR_DC_MODE_HI       2
`define BDCDR_DC_MODE_LO       1
`define BDCDR_DG_ID_MASK       7
`define BDCDR_DG_RSVD6         6
`define BDCDR_DG_CSC_ROUTE     5
`define BDCDR_DG_RETRY_DIS     4
`define BDCDR_DG_RETRY_EXT     3
`define BDCDR_DG_CARD_DISC     2
`define BDCDR_DG_HOST_DISC     1

// ----------------------------------------------------------------------------
// Timing counts in clocks
// ----------------------------------------------------------------------------
`define BDCDR_LAT_SHORT        7'd16
`define BDCDR_LAT_LONG         7'd64
`define BDCDR_DISCARD_SHORT    1024
`define BDCDR_DISCARD_LONG     32768

`endif

//--- hw/bdcdr_pkg.sv
// Types shared by the register group
package bdcdr_pkg;

	// ------------------------------------------------------------------------
	// Interrupt signalling mode
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		BDCDR_MODE_PARALLEL = 2'b00,
		BDCDR_MODE_RSVD     = 2'b01,
		BDCDR_MODE_SER_PAR  = 2'b10,
		BDCDR_MODE_SERIAL   = 2'b11
	} bdcdr_int_mode_t;

	typedef logic [7:0] bdcdr_byte_t;

endpackage : bdcdr_pkg

//--- hw/bdcdr_regs.sv
// Device control and diagnostic register group with APB access
//
// Overview of operation
// [RULE_01] Power hold blocks socket power-off in D3
// [RULE_02] Force bit sets reported 3-volt capability
// [RULE_03] Mode field selects serial or parallel interrupts
// [RULE_04] Control bit 4 reads zero, ignores writes
// [RULE_05] Software writes zero to test bit 3
// [RULE_06] Software writes zero to control bit 0
// [RULE_07] Aux diagnostic bit read/write, resets to one
// [RULE_08] Marked bits cleared only by global reset
// [RULE_09] Software writes only zero to diagnostic register
// [RULE_10] ID masking returns all ones for IDs
// [RULE_11] Diagnostic bit 6 read-only, reads one
// [RULE_12] Routing bit picks status-change interrupt condition
// [RULE_13] Retry-disable bit turns off delayed transactions
// [RULE_14] Retry-extend bit lengthens latency 16 to 64
// [RULE_15] Card discard timer 2^10 or 2^15 clocks
// [RULE_16] Host discard timer 2^10 or 2^15 clocks
// [RULE_17] Software preserves diagnostic bit 0 on write
// [RULE_18] Capability identifier reads fixed 01h
// [RULE_19] Next-item pointer reads fixed 00h
// [RULE_20] Read-only bits ignore writes, byte lane decoded
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "bdcdr_params.svh"

module bdcdr_regs #(
	parameter int ADDR_W        = 12,
	parameter int DISCARD_SHORT = `BDCDR_DISCARD_SHORT,
	parameter int DISCARD_LONG  = `BDCDR_DISCARD_LONG
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     global_reset_n,
	input  wire logic                     ce,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [ADDR_W-1:0]        paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	input  wire logic                     power_state_d3,
	input  wire logic                     power_on_req,
	input  wire logic                     power_off_req,
	output logic                          socket_power_on,
	output logic                          socket_3v_capable,
	output bdcdr_pkg::bdcdr_int_mode_t    interrupt_signal_mode,
	output logic                          serial_irq_en,
	output logic                          parallel_int_en,
	input  wire logic [15:0]              vendor_id_in,
	input  wire logic [15:0]              device_id_in,
	output logic [15:0]                   vendor_id_out,
	output logic [15:0]                   device_id_out,
	input  wire logic                     status_change_event,
	input  wire logic                     legacy_803_bit4,
	input  wire logic [3:0]               legacy_805_hi,
	output logic                          status_change_irq,
	output logic                          delayed_txn_enable,
	output logic [6:0]                    target_latency_limit,
	input  wire logic [1:0]               discard_pending,
	output logic [1:0]                    discard_expired
);
	import bdcdr_pkg::*;

	initial begin
		if (ADDR_W < 10 || ADDR_W > 32)
			$error("ADDR_W must lie between 10 and 32");
		if (DISCARD_SHORT < 1 || DISCARD_LONG < 1 || DISCARD_LONG > 65536)
			$error("Discard counts must lie between 1 and 65536");
	end

	localparam logic [15:0] SHORT_LAST = 16'(DISCARD_SHORT - 1);
	localparam logic [15:0] LONG_LAST  = 16'(DISCARD_LONG - 1);

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	bdcdr_byte_t      dev_ctrl_reg;
	bdcdr_byte_t      diag_ctrl_reg;
	logic             pready_reg;
	logic [31:0]      prdata_reg;
	logic             pslverr_reg;
	logic             socket_power_on_reg;
	logic             socket_3v_capable_reg;
	bdcdr_int_mode_t  int_mode_reg;
	logic             serial_irq_en_reg;
	logic             parallel_int_en_reg;
	logic [15:0]      vendor_id_out_reg;
	logic [15:0]      device_id_out_reg;
	logic             status_change_irq_reg;
	logic             delayed_txn_enable_reg;
	logic [6:0]       target_latency_limit_reg;
	logic [1:0]       discard_expired_reg;
	logic [15:0]      discard_cnt_reg [2];

	logic             access;
	logic             commit_wr;
	logic             hit_dev;
	logic             hit_diag;
	logic             hit_cap;
	logic             hit_next;
	logic             hit_any;
	bdcdr_byte_t      rd_byte;
	logic [1:0]       discard_sel;

	assign access    = psel && penable;
	assign commit_wr = ce && access && pready_reg && pwrite && pstrb[0];
	assign hit_dev   = paddr == ADDR_W'(`BDCDR_ADDR_DEV_CTRL);
	assign hit_diag  = paddr == ADDR_W'(`BDCDR_ADDR_DIAG_CTRL);
	assign hit_cap   = paddr == ADDR_W'(`BDCDR_ADDR_CAP_ID);
	assign hit_next  = paddr == ADDR_W'(`BDCDR_ADDR_NEXT_PTR);
	assign hit_any   = hit_dev || hit_diag || hit_cap || hit_next;

	// ------------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		if (hit_dev)
			rd_byte = dev_ctrl_reg & `BDCDR_WMASK_DEV_CTRL; // RULE_04
		else if (hit_diag)
			rd_byte = diag_ctrl_reg | `BDCDR_FORCE_DIAG_CTRL; // RULE_11
		else if (hit_cap)
			rd_byte = `BDCDR_VAL_CAP_ID; // RULE_18
		else if (hit_next)
			rd_byte = `BDCDR_VAL_NEXT_PTR; // RULE_19
	end

	// ------------------------------------------------------------------------
	// APB answer: one wait state, write commits on the pready edge
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			pready_reg  <= access && !pready_reg;
			pslverr_reg <= access && !pready_reg && !hit_any;
			if (access && !pready_reg && !pwrite)
				prdata_reg <= {24'h00_0000, rd_byte};
			else
				prdata_reg <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------------
	// Software-written bits, held through bus reset
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			dev_ctrl_reg  <= `BDCDR_RST_DEV_CTRL; // RULE_08 RULE_07
			diag_ctrl_reg <= `BDCDR_RST_DIAG_CTRL; // RULE_08
		end else if (commit_wr) begin
			if (hit_dev)
				dev_ctrl_reg <= pwdata[7:0] & `BDCDR_WMASK_DEV_CTRL; // RULE_20 RULE_04
			if (hit_diag)
				diag_ctrl_reg <= (pwdata[7:0] & `BDCDR_WMASK_DIAG_CTRL)
					| `BDCDR_FORCE_DIAG_CTRL; // RULE_20 RULE_11
		end
	end

	// ------------------------------------------------------------------------
	// Socket power and capability
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			socket_power_on_reg   <= 1'b0;
			socket_3v_capable_reg <= 1'b1;
		end else if (ce) begin
			if (power_on_req)
				socket_power_on_reg <= 1'b1;
			else if (power_off_req &&
				!(dev_ctrl_reg[`BDCDR_DC_POWER_HOLD] && power_state_d3))
				socket_power_on_reg <= 1'b0; // RULE_01
			socket_3v_capable_reg <= dev_ctrl_reg[`BDCDR_DC_THREE_VOLT]; // RULE_02
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt signalling mode
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mode_reg        <= BDCDR_MODE_SERIAL;
			serial_irq_en_reg   <= 1'b1;
			parallel_int_en_reg <= 1'b0;
		end else if (ce) begin
			int_mode_reg <= bdcdr_int_mode_t'(dev_ctrl_reg[`BDCDR_DC_MODE_HI:`BDCDR_DC_MODE_LO]);
			case (bdcdr_int_mode_t'(dev_ctrl_reg[`BDCDR_DC_MODE_HI:`BDCDR_DC_MODE_LO]))
				BDCDR_MODE_SER_PAR: begin // RULE_03
					serial_irq_en_reg   <= 1'b1;
					parallel_int_en_reg <= 1'b1;
				end
				BDCDR_MODE_SERIAL: begin // RULE_03
					serial_irq_en_reg   <= 1'b1;
					parallel_int_en_reg <= 1'b0;
				end
				default: begin // RULE_03
					serial_irq_en_reg   <= 1'b0;
					parallel_int_en_reg <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Identification masking and status-change routing
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vendor_id_out_reg     <= 16'h0000;
			device_id_out_reg     <= 16'h0000;
			status_change_irq_reg <= 1'b0;
		end else if (ce) begin
			vendor_id_out_reg <= diag_ctrl_reg[`BDCDR_DG_ID_MASK] ?
				`BDCDR_ID_MASKED : vendor_id_in; // RULE_10
			device_id_out_reg <= diag_ctrl_reg[`BDCDR_DG_ID_MASK] ?
				`BDCDR_ID_MASKED : device_id_in; // RULE_10
			if (diag_ctrl_reg[`BDCDR_DG_CSC_ROUTE])
				status_change_irq_reg <= status_change_event
					&& legacy_805_hi == 4'h0; // RULE_12
			else
				status_change_irq_reg <= status_change_event && legacy_803_bit4; // RULE_12
		end
	end

	// ------------------------------------------------------------------------
	// Retry and latency control
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delayed_txn_enable_reg   <= 1'b1;
			target_latency_limit_reg <= `BDCDR_LAT_SHORT;
		end else if (ce) begin
			delayed_txn_enable_reg <= !diag_ctrl_reg[`BDCDR_DG_RETRY_DIS]; // RULE_13
			target_latency_limit_reg <= diag_ctrl_reg[`BDCDR_DG_RETRY_EXT] ?
				`BDCDR_LAT_LONG : `BDCDR_LAT_SHORT; // RULE_14
		end
	end

	// ------------------------------------------------------------------------
	// Discard timers: 0 host side, 1 card side
	// ------------------------------------------------------------------------
	assign discard_sel = {diag_ctrl_reg[`BDCDR_DG_CARD_DISC], diag_ctrl_reg[`BDCDR_DG_HOST_DISC]};

	for (genvar i = 0; i < 2; i++) begin : g_discard
		logic [15:0] last;
		assign last = discard_sel[i] ? SHORT_LAST : LONG_LAST; // RULE_15 RULE_16

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				discard_cnt_reg[i]     <= 16'h0000;
				discard_expired_reg[i] <= 1'b0;
			end else if (ce) begin
				discard_expired_reg[i] <= 1'b0;
				if (!discard_pending[i]) begin
					discard_cnt_reg[i] <= 16'h0000;
				end else if (discard_cnt_reg[i] >= last) begin
					discard_cnt_reg[i]     <= 16'h0000;
					discard_expired_reg[i] <= 1'b1; // RULE_15 RULE_16
				end else begin
					discard_cnt_reg[i] <= discard_cnt_reg[i] + 16'h0001;
				end
			end
		end

		property p_discard_expire;
			@(posedge pclk) disable iff (!presetn || !global_reset_n)
			ce && discard_pending[i] && discard_cnt_reg[i] == last |=> discard_expired_reg[i];
		endproperty
		a_discard_expire: assert property (p_discard_expire) // RULE_15 RULE_16
			else $error("Discard timer did not expire at its limit");
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign pready               = pready_reg;
	assign prdata               = prdata_reg;
	assign pslverr              = pslverr_reg;
	assign socket_power_on      = socket_power_on_reg;
	assign socket_3v_capable    = socket_3v_capable_reg;
	assign interrupt_signal_mode = int_mode_reg;
	assign serial_irq_en        = serial_irq_en_reg;
	assign parallel_int_en      = parallel_int_en_reg;
	assign vendor_id_out        = vendor_id_out_reg;
	assign device_id_out        = device_id_out_reg;
	assign status_change_irq    = status_change_irq_reg;
	assign delayed_txn_enable   = delayed_txn_enable_reg;
	assign target_latency_limit = target_latency_limit_reg;
	assign discard_expired      = discard_expired_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	sequence s_read_wait;
		ce && access && !pready_reg && !pwrite;
	endsequence

	sequence s_read_done;
		ce && access && pready_reg;
	endsequence

	property p_power_hold;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && power_off_req && !power_on_req && power_state_d3
			&& dev_ctrl_reg[`BDCDR_DC_POWER_HOLD] && socket_power_on_reg
			|=> socket_power_on_reg;
	endproperty
	a_power_hold: assert property (p_power_hold) // RULE_01
		else $error("Socket powered down while hold set in D3");

	property p_three_volt;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn |=> socket_3v_capable_reg == $past(dev_ctrl_reg[`BDCDR_DC_THREE_VOLT]);
	endproperty
	a_three_volt: assert property (p_three_volt) // RULE_02
		else $error("Three-volt capability does not follow force bit");

	property p_mode_parallel;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn && dev_ctrl_reg[2:1] == 2'b00 |=> !serial_irq_en_reg && parallel_int_en_reg;
	endproperty
	a_mode_parallel: assert property (p_mode_parallel) // RULE_03
		else $error("Mode 00 must give parallel interrupts only");

	property p_mode_serial;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn && dev_ctrl_reg[2:1] == 2'b11 |=> serial_irq_en_reg && !parallel_int_en_reg;
	endproperty
	a_mode_serial: assert property (p_mode_serial) // RULE_03
		else $error("Mode 11 must give serialized interrupts only");

	property p_rsvd4_read;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		s_read_wait ##0 hit_dev ##1 s_read_done |-> prdata_reg[`BDCDR_DC_RSVD4] == 1'b0;
	endproperty
	a_rsvd4_read: assert property (p_rsvd4_read) // RULE_04
		else $error("Control bit 4 read back nonzero");

	property p_bus_reset_keeps;
		@(posedge pclk) disable iff (!global_reset_n)
		!presetn |=> $stable(dev_ctrl_reg) && $stable(diag_ctrl_reg);
	endproperty
	a_bus_reset_keeps: assert property (p_bus_reset_keeps) // RULE_08
		else $error("Register bits changed under bus reset");

	property p_id_mask;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn && diag_ctrl_reg[`BDCDR_DG_ID_MASK] |=> vendor_id_out_reg == `BDCDR_ID_MASKED
			&& device_id_out_reg == `BDCDR_ID_MASKED;
	endproperty
	a_id_mask: assert property (p_id_mask) // RULE_10
		else $error("Masked identifiers not all ones");

	property p_diag6_read;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		s_read_wait ##0 hit_diag ##1 s_read_done |-> prdata_reg[`BDCDR_DG_RSVD6];
	endproperty
	a_diag6_read: assert property (p_diag6_read) // RULE_11
		else $error("Diagnostic bit 6 read back zero");

	property p_csc_route;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn && status_change_event && diag_ctrl_reg[`BDCDR_DG_CSC_ROUTE]
			&& legacy_805_hi == 4'h0 |=> status_change_irq_reg;
	endproperty
	a_csc_route: assert property (p_csc_route) // RULE_12
		else $error("Status change not routed with routing bit set");

	property p_retry_dis;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn && diag_ctrl_reg[`BDCDR_DG_RETRY_DIS] |=> !delayed_txn_enable_reg;
	endproperty
	a_retry_dis: assert property (p_retry_dis) // RULE_13
		else $error("Delayed transactions left enabled");

	property p_latency;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && presetn |=> target_latency_limit_reg ==
			($past(diag_ctrl_reg[`BDCDR_DG_RETRY_EXT]) ? 7'd64 : 7'd16);
	endproperty
	a_latency: assert property (p_latency) // RULE_14
		else $error("Latency limit does not follow retry-extend bit");

	property p_cap_read;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		s_read_wait ##0 (hit_cap || hit_next) ##1 s_read_done
			|-> prdata_reg == (hit_cap ? 32'h0000_0001 : 32'h0000_0000);
	endproperty
	a_cap_read: assert property (p_cap_read) // RULE_18 RULE_19
		else $error("Capability bytes read wrong value");

	property p_write_dev;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		commit_wr && hit_dev |=> dev_ctrl_reg == ($past(pwdata[7:0]) & 8'hef);
	endproperty
	a_write_dev: assert property (p_write_dev) // RULE_20
		else $error("Control write not stored as masked");

	property p_pready_pulse;
		@(posedge pclk) disable iff (!presetn || !global_reset_n)
		ce && pready_reg ##1 ce |-> !pready_reg;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) // RULE_20
		else $error("pready held for more than one cycle");

endmodule : bdcdr_regs
